// file: verilog/dc_drive_pkg.sv
// Constants and types for the direct-mode coil drive block
package dc_drive_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [6:0] DIRECT_PAIR_ADDR = 7'h2d;
  localparam logic [31:0] DIRECT_PAIR_RESET = 32'h0;
  localparam int COIL_A_LSB = 0;
  localparam int COIL_A_MSB = 8;
  localparam int COIL_B_LSB = 16;
  localparam int COIL_B_MSB = 24;

  // ****************************************
  // Chopper and scaling constants
  // ****************************************
  // 255 slots per cycle, so a magnitude of 255 is fully on
  localparam logic [7:0] PWM_LAST = 8'hfe;
  localparam logic [7:0] ATTEN_FULL = 8'hff;
  localparam logic [1:0] OPTION_A_CODE = 2'h1;
  localparam logic [4:0] SCALE_RESET = 5'h0;
  // Plain defaults; size them for the real clock rate
  localparam int unsigned STANDSTILL_UNIT_CYCLES = 1024;
  localparam int unsigned HOLD_UNIT_CYCLES = 1024;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_RUN = 2'b01,
    ST_DECAY = 2'b10
  } scale_state_t;

endpackage

// file: verilog/coil_pwm_if.sv
// Link between the drive controller and one full-bridge chopper
`timescale 1ns/100ps
`default_nettype none
interface coil_pwm_if;
  logic enable;
  logic current_mode;
  logic cycle_start;
  logic [7:0] cnt;
  logic [7:0] duty;
  logic negative;
  logic [7:0] limit;
  logic [7:0] sense;
  logic pos;
  logic neg;
  logic tripped;
  modport ctrl (
    output enable, current_mode, cycle_start, cnt, duty, negative, limit, sense,
    input pos, neg, tripped
  );
  modport bridge (
    input enable, current_mode, cycle_start, cnt, duty, negative, limit, sense,
    output pos, neg, tripped
  );
endinterface
`default_nettype wire

// file: verilog/coil_bridge.sv
// Chopper for one full-bridge coil output
`timescale 1ns/100ps
`default_nettype none
module coil_bridge (
  input wire logic clk_i,
  input wire logic resetn_i,
  coil_pwm_if.bridge port
);
  import dc_drive_pkg::*;

  logic trip_reg;
  logic pos_reg;
  logic neg_reg;

  // ****************************************
  // Per-coil current trip and drive
  // ****************************************
  wire over_limit = port.current_mode && (port.sense >= port.limit);
  wire drive = port.enable && (port.duty > port.cnt) && !trip_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      trip_reg <= 1'b0;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end
    else
    begin
      // Trip lasts to the end of the cycle, avoiding chatter on sense noise
      trip_reg <= port.cycle_start ? 1'b0 : (trip_reg | over_limit);
      pos_reg <= drive && !port.negative;
      neg_reg <= drive && port.negative;
    end
  end

  assign port.pos = pos_reg;
  assign port.neg = neg_reg;
  assign port.tripped = trip_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_bridge_exclusive;
    !(pos_reg && neg_reg);
  endproperty
  a_bridge_exclusive: assert property (p_bridge_exclusive)
    else $error("both bridge sides driven");

  property p_trip_blocks;
    (trip_reg && !port.cycle_start) |=> (!pos_reg && !neg_reg);
  endproperty
  a_trip_blocks: assert property (p_trip_blocks)
    else $error("coil driven after current trip");

  property p_polarity;
    (drive && port.negative) |=> (neg_reg && !pos_reg);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("negative value did not drive the negative side");
endmodule
`default_nettype wire

// file: verilog/direct_mode_dc_coil_drive.sv
// Direct-mode drive of two DC motors or solenoids from one register
`timescale 1ns/100ps
`default_nettype none
module direct_mode_dc_coil_drive #(
  parameter int unsigned POWERDOWN_UNIT = dc_drive_pkg::STANDSTILL_UNIT_CYCLES,
  parameter int unsigned HOLD_UNIT = dc_drive_pkg::HOLD_UNIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic direct_mode_i,
  input wire logic voltage_pwm_mode_i,
  input wire logic pwm_autoscale_i,
  input wire logic [3:0] chopper_off_time_i,
  input wire logic [4:0] hold_current_level_i,
  input wire logic [4:0] run_current_level_i,
  input wire logic [3:0] hold_transition_delay_i,
  input wire logic [7:0] standstill_powerdown_delay_i,
  input wire logic [1:0] option_a_i,
  input wire logic [7:0] sense_a_i,
  input wire logic [7:0] sense_b_i,
  input wire logic step_i,
  output logic step_to_sequencer_o,
  output logic motion_halt_o,
  output logic driver_enable_o,
  output logic option_a_o,
  output logic [4:0] current_scale_o,
  output logic coil_a_pos_o,
  output logic coil_a_neg_o,
  output logic coil_b_pos_o,
  output logic coil_b_neg_o
);
  import dc_drive_pkg::*;

  function automatic logic [7:0] magnitude(input logic signed [8:0] v);
    logic [8:0] m;
    m = v[8] ? 9'(-v) : 9'(v);
    // -256 has no positive twin; clip it to full scale
    magnitude = m[8] ? 8'hff : m[7:0];
  endfunction

  function automatic logic [7:0] scaled_limit(input logic [4:0] s, input logic [7:0] mag);
    logic [12:0] p;
    p = 13'({8'h0, s} + 13'd1) * 13'(mag);
    scaled_limit = p[12:5];
  endfunction

  function automatic logic [7:0] attenuate(input logic [7:0] mag, input logic [7:0] a);
    logic [15:0] p;
    p = 16'(mag) * (16'(a) + 16'd1);
    attenuate = p[15:8];
  endfunction

  // ****************************************
  // Register and read port
  // ****************************************
  logic [31:0] pair_reg;
  logic [31:0] rdata_reg;
  wire pair_hit = (reg_addr_i == DIRECT_PAIR_ADDR);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pair_reg <= DIRECT_PAIR_RESET;
    else if (reg_wr_i && pair_hit)
      pair_reg <= reg_wdata_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_reg <= 32'h0;
    else if (reg_rd_i)
      rdata_reg <= pair_hit ? pair_reg : 32'h0;
  end

  wire signed [8:0] raw_a = pair_reg[COIL_A_MSB:COIL_A_LSB];
  wire signed [8:0] raw_b = pair_reg[COIL_B_MSB:COIL_B_LSB];

  // ****************************************
  // Step pin synchroniser
  // ****************************************
  logic step_s1_reg;
  logic step_s2_reg;
  logic step_s3_reg;
  logic step_lvl_reg;
  logic step_seq_reg;
  wire step_rise = step_s2_reg && step_s3_reg && !step_lvl_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      step_s1_reg <= 1'b0;
      step_s2_reg <= 1'b0;
      step_s3_reg <= 1'b0;
      step_lvl_reg <= 1'b0;
      step_seq_reg <= 1'b0;
    end
    else
    begin
      step_s1_reg <= step_i;
      step_s2_reg <= step_s1_reg;
      step_s3_reg <= step_s2_reg;
      if (step_s2_reg == step_s3_reg)
        step_lvl_reg <= step_s2_reg;
      step_seq_reg <= step_rise && !direct_mode_i;
    end
  end

  // ****************************************
  // Chopper cycle and value latching
  // ****************************************
  logic [7:0] cnt_reg;
  logic [7:0] mag_a_reg;
  logic [7:0] mag_b_reg;
  logic neg_a_reg;
  logic neg_b_reg;
  logic [7:0] atten_reg;
  logic [7:0] atten_next;
  wire cycle_start = (cnt_reg == PWM_LAST);
  wire voltage_reg_mode = voltage_pwm_mode_i && pwm_autoscale_i;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_reg <= 8'h0;
      mag_a_reg <= 8'h0;
      mag_b_reg <= 8'h0;
      neg_a_reg <= 1'b0;
      neg_b_reg <= 1'b0;
      atten_reg <= ATTEN_FULL;
    end
    else
    begin
      cnt_reg <= cycle_start ? 8'h0 : cnt_reg + 8'h1;
      if (cycle_start)
      begin
        // Direct copy, no device-side ramp
        mag_a_reg <= direct_mode_i ? magnitude(raw_a) : 8'h0;
        mag_b_reg <= direct_mode_i ? magnitude(raw_b) : 8'h0;
        neg_a_reg <= raw_a[8];
        neg_b_reg <= raw_b[8];
        atten_reg <= atten_next;
      end
    end
  end

  // ****************************************
  // Run/hold current scaling
  // ****************************************
  scale_state_t state_reg;
  scale_state_t state_next;
  logic [4:0] scale_reg;
  logic [4:0] scale_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  wire [31:0] pd_target = 32'(standstill_powerdown_delay_i) * 32'(POWERDOWN_UNIT);
  wire [31:0] hd_target = 32'(hold_transition_delay_i) * 32'(HOLD_UNIT);

  always_comb
  begin
    state_next = state_reg;
    scale_next = scale_reg;
    timer_next = timer_reg + 32'h1;
    case (state_reg)
      ST_HOLD:
      begin
        scale_next = hold_current_level_i;
        timer_next = 32'h0;
      end
      ST_RUN:
      begin
        scale_next = run_current_level_i;
        if (timer_reg >= pd_target)
        begin
          state_next = ST_DECAY;
          timer_next = 32'h0;
        end
      end
      ST_DECAY:
      begin
        if (scale_reg <= hold_current_level_i)
        begin
          state_next = ST_HOLD;
          scale_next = hold_current_level_i;
        end
        else if (timer_reg >= hd_target)
        begin
          scale_next = scale_reg - 5'h1;
          timer_next = 32'h0;
        end
      end
      default:
        state_next = ST_HOLD;
    endcase
    // Only a step pulse restarts the run phase, for both coils at once
    if (step_rise)
    begin
      state_next = ST_RUN;
      scale_next = run_current_level_i;
      timer_next = 32'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= ST_HOLD;
      scale_reg <= SCALE_RESET;
      timer_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      scale_reg <= scale_next;
      timer_reg <= timer_next;
    end
  end

  // ****************************************
  // Current limits and shared attenuation
  // ****************************************
  wire [7:0] limit_a = scaled_limit(scale_reg, mag_a_reg);
  wire [7:0] limit_b = scaled_limit(scale_reg, mag_b_reg);
  wire a_larger = (mag_a_reg >= mag_b_reg);
  wire over = a_larger ? (sense_a_i >= limit_a) : (sense_b_i >= limit_b);

  always_comb
  begin
    atten_next = atten_reg;
    if (!voltage_reg_mode)
      atten_next = ATTEN_FULL;
    else if (over && atten_reg != 8'h0)
      atten_next = atten_reg - 8'h1;
    else if (!over && atten_reg != ATTEN_FULL)
      atten_next = atten_reg + 8'h1;
  end

  // ****************************************
  // Bridges and outputs
  // ****************************************
  coil_pwm_if coil_a_if();
  coil_pwm_if coil_b_if();
  wire drive_ok = direct_mode_i && (chopper_off_time_i != 4'h0);
  wire cur_mode = !voltage_pwm_mode_i;

  // One attenuation for both coils keeps their voltage ratio
  assign coil_a_if.duty = attenuate(mag_a_reg, atten_reg);
  assign coil_b_if.duty = attenuate(mag_b_reg, atten_reg);
  assign coil_a_if.enable = driver_enable_o;
  assign coil_b_if.enable = driver_enable_o;
  assign coil_a_if.current_mode = cur_mode;
  assign coil_b_if.current_mode = cur_mode;
  assign coil_a_if.cycle_start = cycle_start;
  assign coil_b_if.cycle_start = cycle_start;
  assign coil_a_if.cnt = cnt_reg;
  assign coil_b_if.cnt = cnt_reg;
  assign coil_a_if.negative = neg_a_reg;
  assign coil_b_if.negative = neg_b_reg;
  assign coil_a_if.limit = limit_a;
  assign coil_b_if.limit = limit_b;
  assign coil_a_if.sense = sense_a_i;
  assign coil_b_if.sense = sense_b_i;

  coil_bridge u_bridge_a (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .port(coil_a_if.bridge)
  );

  coil_bridge u_bridge_b (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .port(coil_b_if.bridge)
  );

  logic enable_reg;
  logic halt_reg;
  logic option_a_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      enable_reg <= 1'b0;
      halt_reg <= 1'b0;
      option_a_reg <= 1'b0;
    end
    else
    begin
      enable_reg <= drive_ok;
      halt_reg <= direct_mode_i;
      option_a_reg <= direct_mode_i && (hold_current_level_i == 5'h0)
        && (option_a_i == OPTION_A_CODE) && (state_reg == ST_HOLD);
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign step_to_sequencer_o = step_seq_reg;
  assign motion_halt_o = halt_reg;
  assign driver_enable_o = enable_reg;
  assign option_a_o = option_a_reg;
  assign current_scale_o = scale_reg;
  assign coil_a_pos_o = coil_a_if.pos;
  assign coil_a_neg_o = coil_a_if.neg;
  assign coil_b_pos_o = coil_b_if.pos;
  assign coil_b_neg_o = coil_b_if.neg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_pair_write;
    (reg_wr_i && pair_hit) |=> (pair_reg == $past(reg_wdata_i));
  endproperty
  a_pair_write: assert property (p_pair_write)
    else $error("direct pair register not written");

  sequence s_new_cycle;
    cycle_start && direct_mode_i;
  endsequence
  property p_latch_cycle;
    s_new_cycle |=> (mag_a_reg == magnitude($past(raw_a)))
      && (mag_b_reg == magnitude($past(raw_b)));
  endproperty
  a_latch_cycle: assert property (p_latch_cycle)
    else $error("coil values not taken at cycle start");

  property p_hold_mid_cycle;
    !cycle_start |=> $stable(mag_a_reg) && $stable(neg_a_reg);
  endproperty
  a_hold_mid_cycle: assert property (p_hold_mid_cycle)
    else $error("coil value changed inside a chopper cycle");

  property p_off_time_zero;
    (chopper_off_time_i == 4'h0)[*2] |=> !driver_enable_o ##1
      !(coil_a_pos_o || coil_a_neg_o || coil_b_pos_o || coil_b_neg_o);
  endproperty
  a_off_time_zero: assert property (p_off_time_zero)
    else $error("bridge active with zero off time");

  property p_step_run;
    step_rise |=> (state_reg == ST_RUN) && (scale_reg == $past(run_current_level_i));
  endproperty
  a_step_run: assert property (p_step_run)
    else $error("step pulse did not raise current to run level");

  property p_no_restart;
    (state_reg == ST_HOLD && !step_rise) |=> (state_reg == ST_HOLD);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("run phase began without a step pulse");

  property p_step_ignored;
    direct_mode_i |=> !step_to_sequencer_o && motion_halt_o;
  endproperty
  a_step_ignored: assert property (p_step_ignored)
    else $error("step passed to sequencer in direct mode");

  property p_no_autoscale;
    (cycle_start && !voltage_reg_mode) |=> (atten_reg == ATTEN_FULL);
  endproperty
  a_no_autoscale: assert property (p_no_autoscale)
    else $error("attenuation applied without autoscale");

  property p_atten_down;
    (cycle_start && voltage_reg_mode && over && atten_reg != 8'h0)
      |=> (atten_reg == $past(atten_reg) - 8'h1);
  endproperty
  a_atten_down: assert property (p_atten_down)
    else $error("current limit did not reduce PWM");

  property p_voltage_no_trip;
    (!cur_mode && !cycle_start && !coil_a_if.tripped && !coil_b_if.tripped)
      |=> !coil_a_if.tripped && !coil_b_if.tripped;
  endproperty
  a_voltage_no_trip: assert property (p_voltage_no_trip)
    else $error("current trip taken in voltage PWM mode");

  property p_limit_tracks_scale;
    (mag_a_reg == 8'hff) |-> (limit_a == {scale_reg, 3'h7});
  endproperty
  a_limit_tracks_scale: assert property (p_limit_tracks_scale)
    else $error("full magnitude limit does not follow current scale");

  property p_half_limit;
    (scale_reg == 5'h1f && mag_a_reg == 8'h80) |-> (limit_a == 8'h80);
  endproperty
  a_half_limit: assert property (p_half_limit)
    else $error("half magnitude does not give half the current limit");
endmodule
`default_nettype wire

// file: sim/coil_load_model.sv
// Behavioural load of two DC motors or solenoids that reports coil current
`timescale 1ns/100ps
`default_nettype none
module coil_load_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] drive_a_i,
  input wire logic [1:0] drive_b_i,
  input wire logic stall_a_i,
  input wire logic stall_b_i,
  output logic [7:0] sense_a_o,
  output logic [7:0] sense_b_o
);
  // ****************************************
  // Current model
  // ****************************************
  // Locked rotor: no back-EMF, current climbs fast and does not decay.
  // Free motor: back-EMF caps current at 16, so only a limit of 16 or less is reached.
  function automatic logic [7:0] next_current(logic [7:0] i, logic on, logic stall);
    logic [8:0] up;
    up = {1'b0, i} + (stall ? 9'h020 : 9'h001);
    if (stall)
      return on ? (up[8] ? 8'hff : up[7:0]) : i;
    if (!on)
      return i - (i >> 2);
    return (i >= 8'h10) ? i : up[7:0];
  endfunction

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sense_a_o <= 8'h00;
      sense_b_o <= 8'h00;
    end
    else
    begin
      sense_a_o <= next_current(sense_a_o, |drive_a_i, stall_a_i);
      sense_b_o <= next_current(sense_b_o, |drive_b_i, stall_b_i);
    end
  end
endmodule
`default_nettype wire

// file: sim/direct_mode_dc_coil_drive_bench.sv
// Self-checking bench for the direct-mode coil drive block
`timescale 1ns/100ps
`default_nettype none
module direct_mode_dc_coil_drive_bench;
  import dc_drive_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [31:0] wdata = 32'h0;
  logic direct = 1'b0;
  logic vmode = 1'b1;
  logic autoscale = 1'b0;
  logic [3:0] off_time = 4'h0;
  logic [4:0] hold = 5'h1f;
  logic [4:0] run = 5'h1f;
  logic [3:0] hdelay = 4'h1;
  logic [7:0] pdelay = 8'h14;
  logic [1:0] opt = 2'h0;
  logic step = 1'b0;
  logic stall_a = 1'b0;
  logic stall_b = 1'b0;
  logic [31:0] rdata, rd_val, w;
  logic [7:0] sense_a, sense_b;
  logic step_seq, halt, drv_en, fw, a_pos, a_neg, b_pos, b_neg, seen;
  logic [4:0] scale;
  logic [8:0] vals [8] = '{9'h000, 9'h001, 9'h080, 9'h0ff, 9'h1ff, 9'h180, 9'h101, 9'h100};
  int error_cnt = 0;
  int checks = 0;
  int ap, an, bp, bn;

  always #10 clk = ~clk;

  // Short scaling units keep run and decay phases to a few hundred cycles
  direct_mode_dc_coil_drive #(.POWERDOWN_UNIT(4), .HOLD_UNIT(4)) DUT (
    .clk_i(clk), .resetn_i(resetn), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .direct_mode_i(direct), .voltage_pwm_mode_i(vmode), .pwm_autoscale_i(autoscale),
    .chopper_off_time_i(off_time), .hold_current_level_i(hold),
    .run_current_level_i(run), .hold_transition_delay_i(hdelay),
    .standstill_powerdown_delay_i(pdelay), .option_a_i(opt),
    .sense_a_i(sense_a), .sense_b_i(sense_b), .step_i(step),
    .step_to_sequencer_o(step_seq), .motion_halt_o(halt), .driver_enable_o(drv_en),
    .option_a_o(fw), .current_scale_o(scale), .coil_a_pos_o(a_pos),
    .coil_a_neg_o(a_neg), .coil_b_pos_o(b_pos), .coil_b_neg_o(b_neg)
  );

  coil_load_model load (
    .clk_i(clk), .resetn_i(resetn), .drive_a_i({a_pos, a_neg}),
    .drive_b_i({b_pos, b_neg}), .stall_a_i(stall_a), .stall_b_i(stall_b),
    .sense_a_o(sense_a), .sense_b_o(sense_b)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // All bus tasks start and end on a falling edge
  task automatic reg_write(logic [6:0] a, logic [31:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_read(logic [6:0] a, output logic [31:0] d);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    @(negedge clk);
  endtask

  task automatic set_pair(logic [8:0] a, logic [8:0] b);
    reg_write(DIRECT_PAIR_ADDR, {7'h00, b, 7'h00, a});
  endtask

  function automatic int exp_mag(logic [8:0] f);
    int v;
    v = f;
    return f[8] ? ((v == 256) ? 255 : 512 - v) : v;
  endfunction

  // Period is 255 slots, so any 255-cycle window counts the duty exactly
  task automatic measure();
    repeat (510) @(negedge clk);
    ap = 0;
    an = 0;
    bp = 0;
    bn = 0;
    repeat (255)
    begin
      @(negedge clk);
      ap += a_pos;
      an += a_neg;
      bp += b_pos;
      bn += b_neg;
    end
  endtask

  task automatic duty_case(logic [8:0] a, logic [8:0] b);
    set_pair(a, b);
    measure();
    check("coil_a_pos", a[8] ? 0 : exp_mag(a), ap);
    check("coil_a_neg", a[8] ? exp_mag(a) : 0, an);
    check("coil_b_pos", b[8] ? 0 : exp_mag(b), bp);
    check("coil_b_neg", b[8] ? exp_mag(b) : 0, bn);
  endtask

  task automatic pulse_step();
    seen = 1'b0;
    step = 1'b1;
    repeat (4) @(negedge clk) seen |= step_seq;
    step = 1'b0;
    repeat (6) @(negedge clk) seen |= step_seq;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    void'($urandom(6397));
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    reg_read(DIRECT_PAIR_ADDR, rd_val);
    check("pair_reset", DIRECT_PAIR_RESET, rd_val);
    w = $urandom;
    reg_write(DIRECT_PAIR_ADDR, w);
    reg_write(7'h2c, ~w);
    reg_write(7'h2e, ~w);
    reg_read(DIRECT_PAIR_ADDR, rd_val);
    check("pair_readback", w, rd_val);
    reg_read(7'h2e, rd_val);
    check("unmapped_read", 32'h0, rd_val);
    $display("test registers done");
    pulse_step();
    check("step_forwarded", 1, seen);
    direct = 1'b1;
    @(negedge clk);
    pulse_step();
    check("step_blocked", 0, seen);
    check("motion_halt", 1, halt);
    set_pair(9'h0ff, 9'h101);
    measure();
    check("enable_off", 0, drv_en);
    check("coil_a_idle", 0, ap);
    off_time = 4'h4;
    repeat (2) @(negedge clk);
    check("enable_on", 1, drv_en);
    $display("test enable done");
    // Stalled coil carries high current, which must not bend the duty
    stall_a = 1'b1;
    for (int i = 0; i < 12; i++)
      duty_case(i < 8 ? vals[i] : 9'($urandom), 9'($urandom));
    $display("test voltage duty done");
    stall_a = 1'b0;
    run = 5'h14;
    hold = 5'h05;
    opt = 2'h1;
    pulse_step();
    check("scale_run", run, scale);
    repeat (200) @(negedge clk);
    check("scale_hold", hold, scale);
    repeat (300) @(negedge clk);
    check("scale_stays", hold, scale);
    check("no_option_a", 0, fw);
    hold = 5'h00;
    pulse_step();
    check("option_a_in_run", 0, fw);
    repeat (300) @(negedge clk);
    check("scale_zero", 0, scale);
    check("option_a", 1, fw);
    $display("test scaling done");
    hold = 5'h1f;
    run = 5'h1f;
    opt = 2'h0;
    vmode = 1'b0;
    stall_a = 1'b1;
    pulse_step();
    set_pair(9'h0c8, 9'h0c8);
    measure();
    check("stalled_coil_limited", 1, ap < 200);
    check("free_coil_full", 200, bp);
    $display("test current chopper done");
    vmode = 1'b1;
    autoscale = 1'b1;
    set_pair(9'h050, 9'h0c8);
    measure();
    check("smaller_coil_kept", 8'h50, ap);
    check("larger_coil_free", 8'hc8, bp);
    for (int v = 1; v <= 4; v++)
      set_pair(9'(v * 63), 9'h064);
    set_pair(9'h0ff, 9'h064);
    repeat (2550) @(negedge clk);
    measure();
    check("limited_coil_cut", 1, ap < 255);
    check("other_coil_cut", 1, bp < 100);
    $display("test autoscale done");
    report_and_stop();
  end

  initial
  begin
    #1000000;
    error_cnt++;
    $display("Error watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule
`default_nettype wire
